// File: src/xlate_id_pkg.sv
// Package: register map, field layout, reset values and types of the identification/attribute block
package xlate_id_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_ID_WORD0 = 12'h000;
	localparam logic [11:0] OFF_SEC_CFG1 = 12'h004;
	localparam logic [11:0] OFF_ATTR_REG = 12'h008;
	localparam logic [11:0] OFF_ATTR_STAT = 12'h00C;
	// ----------------------------------------
	// Identification word fields
	// ----------------------------------------
	localparam int SEC_BIT = 31;
	localparam int S1_BIT = 30;
	localparam int S2_BIT = 29;
	localparam int NEST_BIT = 28;
	localparam int MATCH_BIT = 27;
	localparam int LONGD_BIT = 24;
	localparam int IRQ_LSB = 16;
	localparam int WALK_BIT = 14;
	localparam int MAINT_BIT = 13;
	localparam int SIDW_LSB = 9;
	localparam int GRP_LSB = 0;
	// ----------------------------------------
	// Secure config register 1 fields
	// ----------------------------------------
	localparam int OVR_GRP_LSB = 0;
	localparam int OVR_IRQ_LSB = 8;
	localparam logic [7:0] OVR_RESET = 8'h00;
	// ----------------------------------------
	// Multi-format attribute register fields
	// ----------------------------------------
	localparam int FMT_LSB = 8;
	localparam int ATTR_LSB = 0;
	localparam int EXTRA_LSB = 4;
	localparam logic [3:0] ATTR_RESET = 4'h0;
	localparam logic [3:0] EXTRA_RESET = 4'h0;
	localparam logic [1:0] FMT_RESET = 2'h0;
	localparam logic [1:0] FMT_ATTR = 2'h1;
	// ----------------------------------------
	// Attribute encodings
	// ----------------------------------------
	localparam logic [1:0] ENC_00 = 2'h0;
	localparam logic [1:0] ENC_01 = 2'h1;
	localparam logic [1:0] ENC_10 = 2'h2;
	localparam logic [1:0] ENC_11 = 2'h3;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {MT_STRONG, MT_DEVICE, MT_NORMAL, MT_UNPRED} mem_type_t;
	typedef enum logic [1:0] {CA_NA, CA_NC, CA_WT, CA_WB} cache_t;

	typedef struct packed {
		mem_type_t mtype;
		cache_t outer;
		cache_t inner;
		logic unpred;
	} attr_decode_t;

	typedef struct packed {
		logic sec;
		logic s1;
		logic s2;
		logic nest;
		logic match;
		logic longd;
		logic walk;
		logic maint;
		logic [7:0] irq;
		logic [3:0] sidw;
		logic [7:0] grp;
	} caps_t;
endpackage : xlate_id_pkg

// File: src/mem_attr_decode.sv
// Memory-attribute field decoder
`timescale 1ns/1ps
module mem_attr_decode
	import xlate_id_pkg::*;
(
	// Attribute in
	input wire logic [3:0] memory_attribute_field,
	// Decode out
	output attr_decode_t dec
);
	always_comb begin
		dec = '{mtype: MT_NORMAL, outer: CA_NA, inner: CA_NA, unpred: 1'b0};
		if (memory_attribute_field[3:2] == ENC_00) begin
			dec.outer = CA_NA;
			dec.inner = CA_NA;
			if (memory_attribute_field[1:0] == ENC_00) begin
				dec.mtype = MT_STRONG;
			end else if (memory_attribute_field[1:0] == ENC_01) begin
				dec.mtype = MT_DEVICE;
			end else begin
				dec.mtype = MT_UNPRED;
				dec.unpred = 1'b1;
			end
		end else begin
			dec.mtype = MT_NORMAL;
			dec.outer = cache_t'(memory_attribute_field[3:2]);
			dec.inner = cache_t'(memory_attribute_field[1:0]);
			if (memory_attribute_field[1:0] == ENC_00) begin
				dec.inner = CA_NA;
				dec.unpred = 1'b1;
			end
		end
	end
endmodule : mem_attr_decode

// File: src/xlate_id_regs.sv
// Identification word, secure override, multi-format attribute register and APB slave
//
// Notes on behaviour
// - Upper attribute bits 00 mean strongly-ordered or device, no cacheability.
// - Nonzero upper pair means normal memory; outer cacheability NC, WT, WB.
// - Lower bits 00 strongly-ordered, 01 device; 10 and 11 unpredictable.
// - Normal memory inner cacheability 01 NC, 10 WT, 11 WB; 00 unpredictable.
// - Reserved field reads back last successfully written value.
// - Unwritten reserved field reads its reset value.
// - Writing a reserved field still updates its own storage.
// - Reserved field value affects nothing but readback.
// - Format change making field meaningful applies its last written value.
// - Identification word is read-only 32 bits; writes have no effect.
// - Bits 23:16 report context interrupt count, 0 to 128.
// - Non-secure reads of irq and group counts return secure overrides.
// - Bit 14 reports coherent walk support.
// - Bit 13 reports broadcast maintenance support.
// - Bits 12:9 report stream identifier width, 0 to 15.
// - Bits 7:0 report mapping group count, at least 1 with matching.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module xlate_id_regs
	import xlate_id_pkg::*;
#(
	parameter logic SEC_IMPL = 1'b1,
	parameter logic S1_IMPL = 1'b1,
	parameter logic S2_IMPL = 1'b1,
	parameter logic NEST_IMPL = 1'b1,
	parameter logic MATCH_IMPL = 1'b1,
	parameter logic LONGD_IMPL = 1'b0,
	parameter logic WALK_IMPL = 1'b1,
	parameter logic MAINT_IMPL = 1'b1,
	parameter logic [7:0] IRQ_IMPL = 8'h08,
	parameter logic [3:0] SIDW_IMPL = 4'hA,
	parameter logic [7:0] GRP_IMPL = 8'h10
)(
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [2:0] PPROT,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Decoded attribute
	output attr_decode_t ATTR_DEC,
	output logic ATTR_ACTIVE
);
	// ----------------------------------------
	// Implemented capabilities
	// ----------------------------------------
	caps_t caps;
	always_comb begin
		caps.sec = SEC_IMPL;
		caps.nest = NEST_IMPL;
		caps.s1 = S1_IMPL | NEST_IMPL;
		caps.s2 = S2_IMPL | NEST_IMPL;
		caps.match = MATCH_IMPL;
		caps.longd = LONGD_IMPL;
		caps.walk = WALK_IMPL;
		caps.maint = MAINT_IMPL;
		caps.irq = (IRQ_IMPL > 8'd128) ? 8'd128 : IRQ_IMPL;
		caps.sidw = SIDW_IMPL;
		caps.grp = (MATCH_IMPL && GRP_IMPL == 8'd0) ? 8'd1 : ((GRP_IMPL > 8'd127) ? 8'd127 : GRP_IMPL);
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] ovr_irq_reg, ovr_irq_next;
	logic [7:0] ovr_grp_reg, ovr_grp_next;
	logic [1:0] fmt_reg, fmt_next;
	logic [3:0] attr_reg, attr_next;
	logic [3:0] extra_reg, extra_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	attr_decode_t dec_reg, dec_next;
	logic active_reg, active_next;
	attr_decode_t dec_w;
	logic [31:0] id_word;
	logic nonsec;
	logic setup;
	logic wr;

	assign nonsec = PPROT[1];
	assign setup = PSEL && !PENABLE;
	assign wr = setup && PWRITE;

	mem_attr_decode u_dec (
		.memory_attribute_field(attr_reg),
		.dec(dec_w)
	);

	// ----------------------------------------
	// Identification word view
	// ----------------------------------------
	always_comb begin
		id_word = ZERO_WORD;
		id_word[SEC_BIT] = caps.sec & ~nonsec;
		id_word[S1_BIT] = caps.s1;
		id_word[S2_BIT] = caps.s2;
		id_word[NEST_BIT] = caps.nest;
		id_word[MATCH_BIT] = caps.match;
		id_word[LONGD_BIT] = caps.longd;
		id_word[IRQ_LSB +: 8] = (caps.sec && nonsec) ? ovr_irq_reg : caps.irq;
		id_word[WALK_BIT] = caps.walk;
		id_word[MAINT_BIT] = caps.maint;
		id_word[SIDW_LSB +: 4] = caps.sidw;
		id_word[GRP_LSB +: 8] = (caps.sec && nonsec) ? ovr_grp_reg : caps.grp;
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		ovr_irq_next = ovr_irq_reg;
		ovr_grp_next = ovr_grp_reg;
		fmt_next = fmt_reg;
		attr_next = attr_reg;
		extra_next = extra_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		if (setup) begin
			pready_next = 1'b1;
			prdata_next = ZERO_WORD;
			if (PADDR == OFF_ID_WORD0) begin
				if (!PWRITE) begin
					prdata_next = id_word;
				end
			end else if (PADDR == OFF_SEC_CFG1) begin
				if (nonsec) begin
					pslverr_next = 1'b1;
				end else if (wr) begin
					if (PSTRB[0]) begin
						ovr_grp_next = PWDATA[OVR_GRP_LSB +: 8];
					end
					if (PSTRB[1]) begin
						ovr_irq_next = PWDATA[OVR_IRQ_LSB +: 8];
					end
				end else begin
					prdata_next[OVR_GRP_LSB +: 8] = ovr_grp_reg;
					prdata_next[OVR_IRQ_LSB +: 8] = ovr_irq_reg;
				end
			end else if (PADDR == OFF_ATTR_REG) begin
				if (wr) begin
					// Every field has own storage whatever the format
					if (PSTRB[0]) begin
						attr_next = PWDATA[ATTR_LSB +: 4];
						extra_next = PWDATA[EXTRA_LSB +: 4];
					end
					if (PSTRB[1]) begin
						fmt_next = PWDATA[FMT_LSB +: 2];
					end
				end else begin
					prdata_next[ATTR_LSB +: 4] = attr_reg;
					prdata_next[EXTRA_LSB +: 4] = extra_reg;
					prdata_next[FMT_LSB +: 2] = fmt_reg;
				end
			end else if (PADDR == OFF_ATTR_STAT) begin
				if (!PWRITE) begin
					prdata_next = {22'h0, dec_reg.unpred, active_reg, 1'b0, dec_reg.mtype,
						dec_reg.outer, dec_reg.inner};
				end
			end else begin
				pslverr_next = 1'b1;
			end
		end
	end

	// Attribute only steers the decode while the format gives it meaning
	always_comb begin
		active_next = (fmt_reg == FMT_ATTR);
		dec_next = active_next ? dec_w : '{mtype: MT_STRONG, outer: CA_NA, inner: CA_NA, unpred: 1'b0};
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ovr_irq_reg <= OVR_RESET;
			ovr_grp_reg <= OVR_RESET;
			fmt_reg <= FMT_RESET;
			attr_reg <= ATTR_RESET;
			extra_reg <= EXTRA_RESET;
			prdata_reg <= ZERO_WORD;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			dec_reg <= '{mtype: MT_STRONG, outer: CA_NA, inner: CA_NA, unpred: 1'b0};
			active_reg <= 1'b0;
		end else begin
			ovr_irq_reg <= ovr_irq_next;
			ovr_grp_reg <= ovr_grp_next;
			fmt_reg <= fmt_next;
			attr_reg <= attr_next;
			extra_reg <= extra_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			dec_reg <= dec_next;
			active_reg <= active_next;
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign ATTR_DEC = dec_reg;
	assign ATTR_ACTIVE = active_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_id_ro;
		@(posedge CLOCK) disable iff (!RST_B)
		(wr && PADDR == OFF_ID_WORD0) |=> (PRDATA == ZERO_WORD && !PSLVERR);
	endproperty
	a_id_ro: assert property (p_id_ro) else $error("Id word write returned data");

	property p_ns_irq;
		@(posedge CLOCK) disable iff (!RST_B)
		(setup && !PWRITE && PADDR == OFF_ID_WORD0 && nonsec && caps.sec) |=>
			(PRDATA[23:16] == $past(ovr_irq_reg) && PRDATA[7:0] == $past(ovr_grp_reg));
	endproperty
	a_ns_irq: assert property (p_ns_irq) else $error("Non-secure counts not overridden");

	property p_ns_sec;
		@(posedge CLOCK) disable iff (!RST_B)
		(setup && !PWRITE && PADDR == OFF_ID_WORD0 && nonsec) |=> !PRDATA[31];
	endproperty
	a_ns_sec: assert property (p_ns_sec) else $error("Security flag visible to non-secure");

	property p_sec_fields;
		@(posedge CLOCK) disable iff (!RST_B)
		(setup && !PWRITE && PADDR == OFF_ID_WORD0 && !nonsec) |=>
			(PRDATA[14] == WALK_IMPL && PRDATA[13] == MAINT_IMPL && PRDATA[12:9] == SIDW_IMPL
			&& PRDATA[23:16] <= 8'd128 && PRDATA[31] == SEC_IMPL);
	endproperty
	a_sec_fields: assert property (p_sec_fields) else $error("Id fields wrong");

	property p_grp;
		@(posedge CLOCK) disable iff (!RST_B)
		(setup && !PWRITE && PADDR == OFF_ID_WORD0 && !nonsec && MATCH_IMPL) |=> (PRDATA[7:0] >= 8'd1);
	endproperty
	a_grp: assert property (p_grp) else $error("Group count zero with matching");

	property p_nest;
		@(posedge CLOCK) disable iff (!RST_B)
		(PREADY && PRDATA[28] && $past(PADDR) == OFF_ID_WORD0) |-> (PRDATA[30] && PRDATA[29]);
	endproperty
	a_nest: assert property (p_nest) else $error("Nested without both stages");

	property p_store;
		@(posedge CLOCK) disable iff (!RST_B)
		(wr && PADDR == OFF_ATTR_REG && PSTRB[0]) |=> (extra_reg == $past(PWDATA[7:4]) && attr_reg == $past(PWDATA[3:0]));
	endproperty
	a_store: assert property (p_store) else $error("Reserved field not stored");

	property p_readback;
		@(posedge CLOCK) disable iff (!RST_B)
		(setup && !PWRITE && PADDR == OFF_ATTR_REG) |=> (PRDATA[7:4] == extra_reg && PRDATA[3:0] == attr_reg);
	endproperty
	a_readback: assert property (p_readback) else $error("Stored field readback wrong");

	property p_inactive;
		@(posedge CLOCK) disable iff (!RST_B)
		(fmt_reg != FMT_ATTR) |=> (!ATTR_ACTIVE && ATTR_DEC.mtype == MT_STRONG);
	endproperty
	a_inactive: assert property (p_inactive) else $error("Reserved field steered decode");

	property p_apply;
		@(posedge CLOCK) disable iff (!RST_B)
		(fmt_reg == FMT_ATTR) |=> (ATTR_ACTIVE && ATTR_DEC == $past(dec_w));
	endproperty
	a_apply: assert property (p_apply) else $error("Format change did not apply field");

	property p_dev_nocache;
		@(posedge CLOCK) disable iff (!RST_B)
		(fmt_reg == FMT_ATTR && attr_reg[3:2] == ENC_00) |=> (ATTR_DEC.outer == CA_NA && ATTR_DEC.inner == CA_NA);
	endproperty
	a_dev_nocache: assert property (p_dev_nocache) else $error("Device type shows cacheability");

	property p_so_dev;
		@(posedge CLOCK) disable iff (!RST_B)
		(fmt_reg == FMT_ATTR && attr_reg[3:2] == ENC_00 && !attr_reg[1]) |=>
			(ATTR_DEC.mtype == ($past(attr_reg[0]) ? MT_DEVICE : MT_STRONG));
	endproperty
	a_so_dev: assert property (p_so_dev) else $error("Strongly-ordered or device decode wrong");

	property p_normal;
		@(posedge CLOCK) disable iff (!RST_B)
		(fmt_reg == FMT_ATTR && attr_reg[3:2] != ENC_00) |=>
			(ATTR_DEC.mtype == MT_NORMAL && ATTR_DEC.outer == cache_t'($past(attr_reg[3:2])));
	endproperty
	a_normal: assert property (p_normal) else $error("Normal memory outer decode wrong");

	property p_inner;
		@(posedge CLOCK) disable iff (!RST_B)
		(fmt_reg == FMT_ATTR && attr_reg[3:2] != ENC_00 && attr_reg[1:0] != ENC_00) |=>
			(ATTR_DEC.inner == cache_t'($past(attr_reg[1:0])) && !ATTR_DEC.unpred);
	endproperty
	a_inner: assert property (p_inner) else $error("Normal memory inner decode wrong");

	c_ns_read: cover property (@(posedge CLOCK) setup && nonsec && PADDR == OFF_ID_WORD0);
	c_fmt_on: cover property (@(posedge CLOCK) $rose(ATTR_ACTIVE));
	c_err: cover property (@(posedge CLOCK) PSLVERR);
	c_unpred: cover property (@(posedge CLOCK) ATTR_DEC.unpred);
endmodule : xlate_id_regs

// File: dv/tb_top.sv
// Self-checking testbench for the identification and attribute register block
`timescale 1ns/1ps
module tb_top
	import xlate_id_pkg::*;
;
	// ----------------------------------------
	// Signals and design instance
	// ----------------------------------------
	localparam logic [7:0] IRQ_N = 8'h80;
	localparam logic [3:0] SIDW_N = 4'hF;
	localparam logic [7:0] GRP_N = 8'h7F;
	logic clock, rst_b, psel, penable, pwrite, pready, pslverr, attr_active, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [2:0] pprot;
	attr_decode_t attr_dec;
	int num_errors = 0, cmp_count = 0, cycles = 0;
	xlate_id_regs #(.IRQ_IMPL(IRQ_N), .SIDW_IMPL(SIDW_N), .GRP_IMPL(GRP_N)) dut (.CLOCK(clock), .RST_B(rst_b),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
		.PPROT(pprot), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ATTR_DEC(attr_dec),
		.ATTR_ACTIVE(attr_active));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [2:0] p, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		pprot <= p;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		check({31'h0, pready}, 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s, 3'h0, rd, er);
		check({31'h0, er}, 32'h0);
	endtask : wr
	task automatic rdck(input logic [11:0] a, input logic [2:0] p, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, 4'h0, p, rd, er);
		check(rd, exp);
	endtask : rdck
	function automatic logic [31:0] id_word(input logic ns, input logic [7:0] irq, input logic [7:0] grp);
		logic [31:0] w;
		w = ZERO_WORD;
		w[SEC_BIT] = ~ns;
		w[S1_BIT] = 1'b1;
		w[S2_BIT] = 1'b1;
		w[NEST_BIT] = 1'b1;
		w[MATCH_BIT] = 1'b1;
		w[IRQ_LSB +: 8] = irq;
		w[WALK_BIT] = 1'b1;
		w[MAINT_BIT] = 1'b1;
		w[SIDW_LSB +: 4] = SIDW_N;
		w[GRP_LSB +: 8] = grp;
		return w;
	endfunction : id_word
	function automatic attr_decode_t exp_dec(input logic [3:0] m);
		attr_decode_t e;
		e = '{MT_STRONG, CA_NA, CA_NA, 1'b0};
		if (m[3:2] == ENC_00) begin
			if (m[1:0] == ENC_01) e.mtype = MT_DEVICE;
			else if (m[1]) e = '{MT_UNPRED, CA_NA, CA_NA, 1'b1};
		end else begin
			e.mtype = MT_NORMAL;
			e.outer = cache_t'(m[3:2]);
			e.inner = cache_t'(m[1:0]);
			e.unpred = (m[1:0] == ENC_00);
		end
		return e;
	endfunction : exp_dec
	task automatic chk_dec(input attr_decode_t e, input logic act);
		repeat (2) @(posedge clock);
		@(negedge clock);
		check({24'h0, attr_dec}, {24'h0, e});
		check({31'h0, attr_active}, {31'h0, act});
	endtask : chk_dec
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_id();
		rdck(OFF_ID_WORD0, 3'h0, id_word(1'b0, IRQ_N, GRP_N));
		wr(OFF_ID_WORD0, 32'hFFFF_FFFF, 4'hF);
		rdck(OFF_ID_WORD0, 3'h0, id_word(1'b0, IRQ_N, GRP_N));
		apb(1'b0, 12'h010, 32'h0000_0000, 4'h0, 3'h0, rd, er);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0000_0000);
	endtask : t_id
	task automatic t_nonsecure();
		rdck(OFF_ID_WORD0, 3'h2, id_word(1'b1, 8'h00, 8'h00));
		wr(OFF_SEC_CFG1, 32'h0000_0305, 4'h3);
		rdck(OFF_ID_WORD0, 3'h2, id_word(1'b1, 8'h03, 8'h05));
		rdck(OFF_ID_WORD0, 3'h0, id_word(1'b0, IRQ_N, GRP_N));
		apb(1'b1, OFF_SEC_CFG1, 32'hFFFF_FFFF, 4'hF, 3'h2, rd, er);
		check({31'h0, er}, 32'h1);
		rdck(OFF_SEC_CFG1, 3'h0, 32'h0000_0305);
	endtask : t_nonsecure
	task automatic t_multiformat();
		rdck(OFF_ATTR_REG, 3'h0, 32'h0000_0000);
		wr(OFF_ATTR_REG, 32'h0000_005F, 4'h1);
		rdck(OFF_ATTR_REG, 3'h0, 32'h0000_005F);
		chk_dec('{MT_STRONG, CA_NA, CA_NA, 1'b0}, 1'b0);
		wr(OFF_ATTR_REG, 32'h0000_0100, 4'h2);
		chk_dec('{MT_NORMAL, CA_WB, CA_WB, 1'b0}, 1'b1);
		rdck(OFF_ATTR_REG, 3'h0, 32'h0000_015F);
		wr(OFF_ATTR_REG, 32'h0000_0200, 4'h2);
		chk_dec('{MT_STRONG, CA_NA, CA_NA, 1'b0}, 1'b0);
	endtask : t_multiformat
	task automatic t_decode();
		attr_decode_t e;
		for (int c = 0; c < 16; c++) begin
			wr(OFF_ATTR_REG, {22'h0, FMT_ATTR, 4'h0, 4'(c)}, 4'h3);
			e = exp_dec(4'(c));
			if (e.mtype == MT_UNPRED) begin
				repeat (2) @(posedge clock);
				@(negedge clock);
				check({31'h0, attr_dec.unpred}, 32'h1);
			end else begin
				chk_dec(e, 1'b1);
				rdck(OFF_ATTR_STAT, 3'h0, {22'h0, e.unpred, 1'b1, 1'b0, e.mtype, e.outer, e.inner});
			end
		end
	endtask : t_decode
	task automatic t_reset_again();
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (4) @(posedge clock);
		check({24'h0, attr_dec}, 32'h0000_0000);
		check({31'h0, pready}, 32'h0);
		rst_b <= 1'b1;
		rdck(OFF_ATTR_REG, 3'h0, 32'h0000_0000);
		rdck(OFF_SEC_CFG1, 3'h0, 32'h0000_0000);
		rdck(OFF_ID_WORD0, 3'h2, id_word(1'b1, 8'h00, 8'h00));
		@(negedge clock);
		check({31'h0, attr_active}, 32'h0);
	endtask : t_reset_again
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic test_done();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb, pprot} = '0;
		rst_b = 1'b0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		t_id();
		t_nonsecure();
		t_multiformat();
		t_decode();
		t_reset_again();
		test_done();
	end
endmodule : tb_top
